// ==== hdl/ssi_pkg.sv ====
package ssi_pkg;

    // clock and flash timing
    localparam int unsigned CLK_HZ = 200_000_000;
    localparam int unsigned FLASH_1HZ = 1;
    // half period of the 2 Hz flash in cycles; 1 Hz half period is twice it
    localparam int unsigned HALF_2HZ_CYC = CLK_HZ / (4 * FLASH_1HZ);

    // channel counts
    localparam int unsigned N_IN = 8;
    localparam int unsigned N_OUT = 4;

    // first-cycle flag length in cycles (one logic execution period)
    localparam int unsigned FIRST_CYC_LEN = 16;

    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STAT = 8'h04;
    localparam logic [7:0] REG_CHAN = 8'h08;
    localparam logic [7:0] REG_ERR = 8'h0c;
    localparam logic [7:0] REG_IRQ_STAT = 8'h10;
    localparam logic [7:0] REG_IRQ_EN = 8'h14;
    localparam logic [7:0] REG_IRQ_CLR = 8'h18;

    // control register bit positions
    localparam int unsigned CTRL_START = 0;
    localparam int unsigned CTRL_STOP = 1;
    localparam int unsigned CTRL_VERIFIED = 2;
    localparam int unsigned CTRL_CFG_VALID = 3;

    // interrupt event bit positions
    localparam int unsigned IRQ_RUN = 0;
    localparam int unsigned IRQ_STOP = 1;
    localparam int unsigned IRQ_CRIT = 2;
    localparam int unsigned IRQ_FAULT = 3;
    localparam int unsigned IRQ_W = 4;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0008;

    typedef enum logic [0:0] {
        SSI_STOP = 1'b0,
        SSI_RUN = 1'b1
    } ssi_run_t;

    // module status led colour and pattern
    typedef enum logic [2:0] {
        MS_OFF = 3'b000,
        MS_GREEN = 3'b001,
        MS_RED = 3'b010,
        MS_GREEN_1HZ = 3'b011,
        MS_RED_1HZ = 3'b100,
        MS_RED_2HZ = 3'b101,
        MS_RG_1HZ = 3'b110
    } ssi_ms_t;

    // two-colour led drive
    typedef struct packed {
        logic red;
        logic green;
    } ssi_led_t;

    // external status inputs
    typedef struct packed {
        logic supply_ok;
        logic primary_in_range;
        logic crit_here;
        logic crit_other;
        logic [N_IN-1:0] in_level;
        logic [N_IN-1:0] in_err;
        logic [N_IN-1:0] in_dual;
        logic [N_OUT-1:0] out_on;
        logic [N_OUT-1:0] out_err;
    } ssi_status_t;

endpackage

// ==== hdl/ssi_flash_timebase.sv ====
`timescale 1ns/1ps
module ssi_flash_timebase #(
    parameter int unsigned HALF_CYC = ssi_pkg::HALF_2HZ_CYC
) (
    input wire logic hclk,
    input wire logic hresetn,
    output logic phase_2hz,
    output logic phase_1hz
);

    typedef struct packed {
        logic [31:0] cnt;
        logic p2;
        logic p1;
    } ssi_tb_state_t;

    ssi_tb_state_t s;
    ssi_tb_state_t next_s;

    // one counter feeds both phases so patterns stay locked
    always_comb begin
        next_s = s;
        if (s.cnt >= HALF_CYC - 1) begin
            next_s.cnt = 32'h0;
            next_s.p2 = ~s.p2;
            if (s.p2) begin
                next_s.p1 = ~s.p1;
            end
        end else begin
            next_s.cnt = s.cnt + 32'h1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign phase_2hz = s.p2;
    assign phase_1hz = s.p1;

endmodule

// ==== hdl/ssi_indicator.sv ====
`timescale 1ns/1ps
// Summary of operation
// RL1: module status led dark while supply is out of operating range.
// RL2: repairable external fault flashes module status red/green at 1 Hz.
// RL3: stopped or primary supply out of range flashes green at 1 Hz.
// RL4: steady green only when running and primary supply in range.
// RL5: invalid configuration flashes module status red at 1 Hz.
// RL6: critical error in this module flashes red at 2 Hz.
// RL7: any critical error halts application and switches all outputs off.
// RL8: critical error in another module lights steady red.
// RL9: input led dark when low, green when high, with no error.
// RL10: low input with dual-channel error flashes green in phase with red.
// RL11: high input with error flashes green in antiphase to red.
// RL12: output test error flashes green in phase with red.
// RL13: output led dark while output off and no test error.
// RL14: stop to run only on explicit start command.
// RL15: run to stop only on explicit stop command.
// RL16: commander issues only manual start and stop transitions.
// RL17: after power-up run automatically if configuration verified.
// RL18: start asserts first-cycle flag and clears timers and error states.
// RL19: 1 Hz and 2 Hz patterns come from one shared timebase.
module ssi_indicator #(
    parameter int unsigned HALF_CYC = ssi_pkg::HALF_2HZ_CYC,
    parameter int unsigned FIRST_LEN = ssi_pkg::FIRST_CYC_LEN
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire ssi_pkg::ssi_status_t status_in,
    output ssi_pkg::ssi_led_t module_status_led,
    output logic [ssi_pkg::N_IN-1:0] safe_input_channels,
    output logic [ssi_pkg::N_OUT-1:0] safe_output_channels,
    output logic [ssi_pkg::N_OUT-1:0] output_enable,
    output logic app_running,
    output logic first_cycle,
    output logic clear_errors,
    output logic irq
);

    localparam int SW = $bits(ssi_pkg::ssi_status_t);

    typedef struct packed {
        logic [SW-1:0] sync1;
        logic [SW-1:0] sync2;
        logic [SW-1:0] sync3;
        ssi_pkg::ssi_status_t st;
        logic boot;
        ssi_pkg::ssi_run_t run;
        logic [31:0] first_cnt;
        logic [31:0] first_age;
        logic [31:0] ctrl;
        logic [ssi_pkg::IRQ_W-1:0] irq_stat;
        logic [ssi_pkg::IRQ_W-1:0] irq_en;
        logic dp_wr;
        logic [7:0] dp_addr;
        logic [31:0] rdata;
        ssi_pkg::ssi_led_t ms;
        logic [ssi_pkg::N_IN-1:0] in_led;
        logic [ssi_pkg::N_OUT-1:0] out_led;
        logic [ssi_pkg::N_OUT-1:0] out_en;
        logic first;
        logic clr;
        logic irq;
        logic crit_d;
        logic fault_d;
    } ssi_state_t;

    ssi_state_t s;
    ssi_state_t next_s;
    logic ph2;
    logic ph1;
    ssi_pkg::ssi_status_t st_new;
    ssi_pkg::ssi_ms_t ms_mode;
    logic crit;
    logic fault;
    logic start_cmd;
    logic stop_cmd;
    logic addr_take;

    ////////////////////////////////////////////////////////////////////////////
    // shared flash timebase
    ssi_flash_timebase #(
        .HALF_CYC(HALF_CYC)
    ) u_tb (
        .hclk(hclk),
        .hresetn(hresetn),
        .phase_2hz(ph2),
        .phase_1hz(ph1)
    ); // [RL19]

    // pattern to colour, 1 Hz red flash in phase with ph1, 2 Hz red flash with ph2
    function automatic ssi_pkg::ssi_led_t ms_drive(input ssi_pkg::ssi_ms_t m,
                                                   input logic p1, input logic p2);
        ssi_pkg::ssi_led_t l;
        l = '0;
        unique case (m)
            ssi_pkg::MS_OFF: l = '0;
            ssi_pkg::MS_GREEN: l.green = 1'b1;
            ssi_pkg::MS_RED: l.red = 1'b1;
            ssi_pkg::MS_GREEN_1HZ: l.green = p1;
            ssi_pkg::MS_RED_1HZ: l.red = p1;
            ssi_pkg::MS_RED_2HZ: l.red = p2;
            ssi_pkg::MS_RG_1HZ: begin
                l.red = p1;
                l.green = ~p1;
            end
            default: l = '0;
        endcase
        return l;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // status decode from the filtered inputs
    always_comb begin
        st_new = ssi_pkg::ssi_status_t'(s.sync3);
        crit = s.st.crit_here | s.st.crit_other;
        fault = (|s.st.in_err) | (|s.st.out_err);
        addr_take = hsel & hready & (htrans == ssi_pkg::HTRANS_NONSEQ);
        start_cmd = s.dp_wr && (s.dp_addr == ssi_pkg::REG_CTRL)
                    && hwdata[ssi_pkg::CTRL_START];
        stop_cmd = s.dp_wr && (s.dp_addr == ssi_pkg::REG_CTRL)
                   && hwdata[ssi_pkg::CTRL_STOP];
    end

    // module status priority selection
    always_comb begin
        if (!s.st.supply_ok) begin
            ms_mode = ssi_pkg::MS_OFF; // [RL1]
        end else if (s.st.crit_here) begin
            ms_mode = ssi_pkg::MS_RED_2HZ; // [RL6]
        end else if (s.st.crit_other) begin
            ms_mode = ssi_pkg::MS_RED; // [RL8]
        end else if (!s.ctrl[ssi_pkg::CTRL_CFG_VALID]) begin
            ms_mode = ssi_pkg::MS_RED_1HZ; // [RL5]
        end else if (fault) begin
            ms_mode = ssi_pkg::MS_RG_1HZ; // [RL2]
        end else if (s.run == ssi_pkg::SSI_STOP || !s.st.primary_in_range) begin
            ms_mode = ssi_pkg::MS_GREEN_1HZ; // [RL3]
        end else begin
            ms_mode = ssi_pkg::MS_GREEN; // [RL4]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        next_s = s;
        // three-stage input filter, accept on agreement of stages 2 and 3
        next_s.sync1 = status_in;
        next_s.sync2 = s.sync1;
        next_s.sync3 = s.sync2;
        if (s.sync2 == s.sync3) begin
            next_s.st = st_new;
        end
        next_s.clr = 1'b0;

        // ahb-lite register access
        next_s.dp_wr = addr_take & hwrite;
        next_s.dp_addr = addr_take ? haddr[7:0] : s.dp_addr;
        if (addr_take && !hwrite) begin
            unique case (haddr[7:0])
                ssi_pkg::REG_CTRL: next_s.rdata = s.ctrl;
                ssi_pkg::REG_STAT: next_s.rdata = {24'h0, 2'h0, s.ms, s.first,
                                                   crit, fault, s.run};
                ssi_pkg::REG_CHAN: next_s.rdata = {16'h0, 4'h0, s.st.out_on,
                                                   s.st.in_level};
                ssi_pkg::REG_ERR: next_s.rdata = {16'h0, 4'h0, s.st.out_err,
                                                  s.st.in_err};
                ssi_pkg::REG_IRQ_STAT: next_s.rdata = {28'h0, s.irq_stat};
                ssi_pkg::REG_IRQ_EN: next_s.rdata = {28'h0, s.irq_en};
                default: next_s.rdata = 32'h0;
            endcase
        end
        if (s.dp_wr) begin
            if (s.dp_addr == ssi_pkg::REG_CTRL) begin
                next_s.ctrl = {28'h0, hwdata[ssi_pkg::CTRL_CFG_VALID],
                               hwdata[ssi_pkg::CTRL_VERIFIED], 2'h0};
            end
            if (s.dp_addr == ssi_pkg::REG_IRQ_EN) begin
                next_s.irq_en = hwdata[ssi_pkg::IRQ_W-1:0];
            end
            if (s.dp_addr == ssi_pkg::REG_IRQ_CLR) begin
                next_s.irq_stat = s.irq_stat & ~hwdata[ssi_pkg::IRQ_W-1:0];
            end
        end

        // countdown first, so that a restart inside the flag reloads it
        if (s.first_cnt != 32'h0) begin
            next_s.first_cnt = s.first_cnt - 32'h1;
        end

        // run/stop machine; power-up start window closes on run, a critical error or a ctrl write with verified clear
        if (crit) begin
            next_s.run = ssi_pkg::SSI_STOP; // [RL7]
            next_s.boot = 1'b0;
        end else if (s.run == ssi_pkg::SSI_STOP
                     && (start_cmd || (s.boot && s.ctrl[ssi_pkg::CTRL_VERIFIED]))) begin
            next_s.run = ssi_pkg::SSI_RUN; // [RL14] [RL17]
            next_s.boot = 1'b0;
            next_s.first_cnt = FIRST_LEN; // [RL18]
            next_s.clr = 1'b1; // [RL18]
        end else if (s.run == ssi_pkg::SSI_RUN && stop_cmd) begin
            next_s.run = ssi_pkg::SSI_STOP; // [RL15]
        end
        if (s.dp_wr && (s.dp_addr == ssi_pkg::REG_CTRL) && !hwdata[ssi_pkg::CTRL_VERIFIED]) begin
            next_s.boot = 1'b0; // [RL17]
        end
        next_s.first = (next_s.first_cnt != 32'h0); // [RL18]
        // length of the flag so far, watched by the checks
        if (!next_s.first || next_s.clr) begin
            next_s.first_age = {31'h0, next_s.first};
        end else begin
            next_s.first_age = s.first_age + 32'h1;
        end

        // sticky events, set beats clear
        next_s.crit_d = crit;
        next_s.fault_d = fault;
        if (next_s.run == ssi_pkg::SSI_RUN && s.run == ssi_pkg::SSI_STOP) begin
            next_s.irq_stat[ssi_pkg::IRQ_RUN] = 1'b1;
        end
        if (next_s.run == ssi_pkg::SSI_STOP && s.run == ssi_pkg::SSI_RUN) begin
            next_s.irq_stat[ssi_pkg::IRQ_STOP] = 1'b1;
        end
        if (crit && !s.crit_d) begin
            next_s.irq_stat[ssi_pkg::IRQ_CRIT] = 1'b1;
        end
        if (fault && !s.fault_d) begin
            next_s.irq_stat[ssi_pkg::IRQ_FAULT] = 1'b1;
        end
        next_s.irq = |(next_s.irq_stat & next_s.irq_en);

        // led drive
        next_s.ms = ms_drive(ms_mode, ph1, ph2);
        for (int i = 0; i < ssi_pkg::N_IN; i++) begin
            if (!s.st.supply_ok) begin
                next_s.in_led[i] = 1'b0;
            end else if (s.st.in_err[i] && !s.st.in_level[i] && s.st.in_dual[i]) begin
                next_s.in_led[i] = ph1; // [RL10]
            end else if (s.st.in_err[i] && s.st.in_level[i]) begin
                next_s.in_led[i] = ~ph1; // [RL11]
            end else begin
                next_s.in_led[i] = s.st.in_level[i] & ~s.st.in_err[i]; // [RL9]
            end
        end
        for (int j = 0; j < ssi_pkg::N_OUT; j++) begin
            next_s.out_en[j] = s.st.out_on[j] && !crit
                               && (s.run == ssi_pkg::SSI_RUN); // [RL7]
            if (s.st.out_err[j]) begin
                next_s.out_led[j] = ph1; // [RL12]
            end else begin
                next_s.out_led[j] = next_s.out_en[j]; // [RL13]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '0;
            s.boot <= 1'b1;
            s.ctrl <= ssi_pkg::CTRL_RESET;
            s.st.supply_ok <= 1'b0;
        end else begin
            s <= next_s;
        end
    end

    // outputs from flops; hreadyout and hresp tied to ready and okay
    assign hrdata = s.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign module_status_led = s.ms;
    assign safe_input_channels = s.in_led;
    assign safe_output_channels = s.out_led;
    assign output_enable = s.out_en;
    assign app_running = (s.run == ssi_pkg::SSI_RUN);
    assign first_cycle = s.first;
    assign clear_errors = s.clr;
    assign irq = s.irq;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    a_dark_supply: assert property (@(posedge hclk) disable iff (!hresetn) // [RL1]
        !s.st.supply_ok |=> module_status_led == '0)
        else $error("status led lit with bad supply");
    a_crit_outs: assert property (@(posedge hclk) disable iff (!hresetn) // [RL7]
        crit |=> output_enable == '0 && !app_running)
        else $error("outputs on during critical error");
    a_start_run: assert property (@(posedge hclk) disable iff (!hresetn) // [RL14]
        $rose(app_running) && !$past(s.boot) |-> $past(start_cmd))
        else $error("run entered without start");
    a_auto_start: assert property (@(posedge hclk) disable iff (!hresetn) // [RL17]
        $rose(app_running) && $past(s.boot)
        |-> $past(s.ctrl[ssi_pkg::CTRL_VERIFIED]) || $past(start_cmd))
        else $error("power-up run without verified config");
    a_stop_only: assert property (@(posedge hclk) disable iff (!hresetn) // [RL15]
        $fell(app_running) |-> $past(stop_cmd) || $past(crit))
        else $error("stop entered without cause");
    a_first_flag: assert property (@(posedge hclk) disable iff (!hresetn) // [RL18]
        $rose(app_running) |-> first_cycle && clear_errors)
        else $error("first cycle flag missing");
    a_first_len: assert property (@(posedge hclk) disable iff (!hresetn) // [RL18]
        $fell(first_cycle) |-> $past(s.first_age) == FIRST_LEN)
        else $error("first cycle flag length wrong");
    a_fault_flash: assert property (@(posedge hclk) disable iff (!hresetn) // [RL2]
        s.st.supply_ok && !crit && s.ctrl[ssi_pkg::CTRL_CFG_VALID] && fault
        |=> module_status_led.red == $past(ph1) && module_status_led.green != $past(ph1))
        else $error("fault flash pattern wrong");
    a_green_run: assert property (@(posedge hclk) disable iff (!hresetn) // [RL4]
        s.st.supply_ok && !crit && !fault && s.ctrl[ssi_pkg::CTRL_CFG_VALID]
        && app_running && s.st.primary_in_range |=> module_status_led.green && !module_status_led.red)
        else $error("steady green missing while running");
    a_red_here: assert property (@(posedge hclk) disable iff (!hresetn) // [RL6]
        s.st.supply_ok && s.st.crit_here |=> module_status_led.red == $past(ph2) && !module_status_led.green)
        else $error("fast red flash missing");
    a_red_other: assert property (@(posedge hclk) disable iff (!hresetn) // [RL8]
        s.st.supply_ok && !s.st.crit_here && s.st.crit_other
        |=> module_status_led.red && !module_status_led.green)
        else $error("steady red missing");
    a_in_steady: assert property (@(posedge hclk) disable iff (!hresetn) // [RL9]
        s.st.supply_ok && !s.st.in_err[0] |=> safe_input_channels[0] == $past(s.st.in_level[0]))
        else $error("input led does not follow level");
    a_in_anti: assert property (@(posedge hclk) disable iff (!hresetn) // [RL11]
        s.st.supply_ok && s.st.in_err[0] && s.st.in_level[0] |=> safe_input_channels[0] == !$past(ph1))
        else $error("high input error flash not in antiphase");
    a_out_flash: assert property (@(posedge hclk) disable iff (!hresetn) // [RL12]
        s.st.out_err[0] |=> safe_output_channels[0] == $past(ph1))
        else $error("output test error flash out of phase");
    a_out_dark: assert property (@(posedge hclk) disable iff (!hresetn) // [RL13]
        !s.out_en[0] && !s.st.out_err[0] && $stable(s.st.out_err[0])
        |-> !safe_output_channels[0])
        else $error("output led lit while off");

endmodule

// ==== tb/ssi_ctrl_model.sv ====
`timescale 1ns/1ps
// controller side: relays start, stop and configuration commands over ahb-lite
module ssi_ctrl_model (
    input wire logic hclk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    logic [31:0] ctrl_shadow;

    ////////////////////////////////////////////////////////////////////////////////
    // idle bus at time zero
    initial begin
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        ctrl_shadow = 32'h0000_0008;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // one single word transfer; entered just after a rising edge
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd,
                        output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= ssi_pkg::HTRANS_NONSEQ;
        hwrite <= w;
        hsize <= 3'h2;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        haddr <= ~a; // released address, not left looking valid
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
        hwdata <= ~wd; // released data line
    endtask

    task automatic write(input logic [31:0] a, input logic [31:0] wd);
        logic [31:0] rd;
        xfer(1'b1, a, wd, rd);
    endtask

    task automatic read(input logic [31:0] a, output logic [31:0] rd);
        xfer(1'b0, a, 32'h0000_0000, rd);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // only the two manual transitions are ever commanded
    task automatic start_cmd();
        write(32'(ssi_pkg::REG_CTRL), ctrl_shadow | 32'h1);
    endtask

    task automatic stop_cmd();
        write(32'(ssi_pkg::REG_CTRL), ctrl_shadow | 32'h2);
    endtask

    task automatic set_cfg(input logic valid);
        ctrl_shadow[ssi_pkg::CTRL_CFG_VALID] = valid;
        write(32'(ssi_pkg::REG_CTRL), ctrl_shadow);
    endtask
endmodule

// ==== tb/test_ssi_indicator.sv ====
`timescale 1ns/1ps
module test_ssi_indicator;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel, hwrite, hreadyout, hresp, app_running, first_cycle, clear_errors, irq;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize, code;
    logic [7:0] chin;
    logic [3:0] chout, oen;
    ssi_pkg::ssi_status_t status_in;
    ssi_pkg::ssi_led_t ms;
    int failures = 0;
    int total_checks = 0;
    int seed = 5305;
    int run = 0;
    int cfg = 1;
    int bad, fc, ce;

    always #2.5 hclk = ~hclk;

    ssi_ctrl_model u_ctrl (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

    ssi_indicator #(.HALF_CYC(4), .FIRST_LEN(6)) DUT (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .status_in(status_in), .module_status_led(ms),
        .safe_input_channels(chin), .safe_output_channels(chout), .output_enable(oen),
        .app_running(app_running), .first_cycle(first_cycle), .clear_errors(clear_errors),
        .irq(irq));

    ////////////////////////////////////////////////////////////////////////////////
    // comparison, verdict and watchdog
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        #100000;
        failures++;
        report_and_stop();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // reference pattern of the module status led, highest priority first
    function automatic logic [2:0] exp_ms(ssi_pkg::ssi_status_t s);
        if (!s.supply_ok) return ssi_pkg::MS_OFF;
        if (s.crit_here) return ssi_pkg::MS_RED_2HZ;
        if (s.crit_other) return ssi_pkg::MS_RED;
        if (cfg == 0) return ssi_pkg::MS_RED_1HZ;
        if ((|s.in_err) || (|s.out_err)) return ssi_pkg::MS_RG_1HZ;
        if (run == 0 || !s.primary_in_range) return ssi_pkg::MS_GREEN_1HZ;
        return ssi_pkg::MS_GREEN;
    endfunction

    // apply a status, let the filter settle, then watch 33 samples (1 Hz half = 8)
    task automatic scen(input ssi_pkg::ssi_status_t s);
        logic pr, pg;
        int re, ge;
        @(posedge hclk);
        status_in <= s;
        if (s.crit_here || s.crit_other) run = 0;
        repeat (12) @(posedge hclk);
        #1;
        re = 0;
        ge = 0;
        bad = 0;
        pr = ms.red;
        pg = ms.green;
        repeat (32) begin
            @(posedge hclk);
            #1;
            re += int'(ms.red !== pr);
            ge += int'(ms.green !== pg);
            pr = ms.red;
            pg = ms.green;
            for (int i = 0; i < 8; i++) begin
                if (s.in_err[i]) bad += int'(chin[i] !== (s.in_level[i] ? ~pr : pr));
            end
            for (int i = 0; i < 4; i++) begin
                if (s.out_err[i]) bad += int'(chout[i] !== pr);
            end
        end
        if (re == 8) code = ssi_pkg::MS_RED_2HZ;
        else if (re == 4 && ge == 4) code = ssi_pkg::MS_RG_1HZ;
        else if (re == 4 && ge == 0 && pg === 1'b0) code = ssi_pkg::MS_RED_1HZ;
        else if (ge == 4 && re == 0 && pr === 1'b0) code = ssi_pkg::MS_GREEN_1HZ;
        else if (re == 0 && ge == 0 && {pr, pg} !== 2'b11) code = {1'b0, pr, pg};
        else code = 3'h7;
        check("ms_pattern", 32'(code), 32'(exp_ms(s)));
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        ssi_pkg::ssi_status_t s;
        s = '0;
        s.supply_ok = 1'b1;
        s.primary_in_range = 1'b1;
        status_in = s;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        #1;
        check("run_after_boot", 32'(app_running), 32'h0);
        @(posedge hclk);
        u_ctrl.read(32'(ssi_pkg::REG_CTRL), rd);
        check("ctrl_reset", rd, ssi_pkg::CTRL_RESET);
        u_ctrl.read(32'h0000_0040, rd);
        check("unmapped", rd, 32'h0);
        check("okay_resp", 32'(hresp), 32'h0);
        scen(s); // stopped: green 1 Hz
        u_ctrl.write(32'(ssi_pkg::REG_IRQ_EN), 32'h1);
        u_ctrl.start_cmd();
        run = 1;
        fc = 0;
        ce = 0;
        repeat (20) begin
            #1;
            fc += int'(first_cycle === 1'b1);
            ce += int'(clear_errors === 1'b1);
            @(posedge hclk);
        end
        check("first_cycle_len", 32'(fc), 32'd6);
        check("clear_pulse", 32'(ce), 32'd1);
        check("run_on_start", 32'(app_running), 32'h1);
        check("irq_run", 32'(irq), 32'h1);
        u_ctrl.read(32'(ssi_pkg::REG_IRQ_STAT), rd);
        check("irq_stat", rd & 32'h1, 32'h1);
        u_ctrl.write(32'(ssi_pkg::REG_IRQ_CLR), 32'h1);
        repeat (2) @(posedge hclk);
        #1;
        check("irq_cleared", 32'(irq), 32'h0);
        // steady channel leds from random levels
        s.in_level = 8'($random(seed));
        s.out_on = 4'($random(seed));
        scen(s); // running: steady green
        check("in_leds", 32'(chin), 32'(s.in_level));
        check("out_dark", 32'(chout & ~s.out_on), 32'h0);
        check("out_enable", 32'(oen), 32'(s.out_on));
        u_ctrl.read(32'(ssi_pkg::REG_CHAN), rd);
        check("chan_reg", rd, {20'h0, s.out_on, s.in_level});
        s.primary_in_range = 1'b0;
        scen(s);
        s.primary_in_range = 1'b1;
        s.supply_ok = 1'b0;
        scen(s);
        s.supply_ok = 1'b1;
        // repairable faults: channel leds locked to the red flash
        s.in_err = 8'($random(seed)) | 8'h81;
        s.in_dual = ~s.in_level;
        s.out_err = 4'h5;
        s.out_on = 4'h0;
        scen(s);
        check("led_phase", 32'(bad), 32'h0);
        s.in_err = '0;
        s.out_err = '0;
        u_ctrl.set_cfg(1'b0);
        cfg = 0;
        scen(s);
        u_ctrl.set_cfg(1'b1);
        cfg = 1;
        // stop with the run interrupt masked
        u_ctrl.write(32'(ssi_pkg::REG_IRQ_EN), 32'h0);
        u_ctrl.stop_cmd();
        run = 0;
        @(posedge hclk);
        #1;
        check("stop_cmd", 32'(app_running), 32'h0);
        scen(s);
        check("irq_masked", 32'(irq), 32'h0);
        u_ctrl.start_cmd();
        run = 1;
        s.out_on = 4'hf;
        s.crit_other = 1'b1;
        scen(s);
        check("crit_outputs", 32'(oen), 32'h0);
        check("crit_halt", 32'(app_running), 32'h0);
        s.crit_other = 1'b0;
        s.crit_here = 1'b1;
        scen(s);
        check("crit_here_out", 32'(oen), 32'h0);
        // second power-up: a verified configuration starts without a command
        s.crit_here = 1'b0;
        status_in <= s;
        hresetn <= 1'b0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        u_ctrl.write(32'(ssi_pkg::REG_CTRL), ssi_pkg::CTRL_RESET | (32'h1 << ssi_pkg::CTRL_VERIFIED));
        repeat (3) @(posedge hclk);
        #1;
        check("auto_run", 32'(app_running), 32'h1);
        check("auto_first", 32'(first_cycle), 32'h1);
        report_and_stop();
    end
endmodule
